// ==== utq_usart.sv ====
// Serial transceiver with APB registers, two-level transmit and sync check.
`timescale 1ns/1ns
module utq_usart
  import utq_pkg::*;
(
  input  wire logic                clk,      // System clock, 10 MHz.
  input  wire logic                sys_rst,  // Asynchronous reset, active high.
  input  wire utq_pkg::utq_apb_req_t apb_i,  // APB request from the master.
  output logic              [31:0] prdata,   // APB read data.
  output logic                     pready,   // APB ready.
  output logic                     pslverr,  // APB error on unmapped address.
  input  wire logic                rxd_i,    // Serial input pin.
  output logic                     txd_o,    // Serial output pin value.
  output logic                     txd_oe    // Serial output pin enable.
);
  import utq_pkg::*;

  //============================================================================
  // Declarations.
  utq_state_t  q, d;     // Whole block state and its next value.
  logic        rx_s;     // Synchronised input line.
  logic        lin_ok;   // Sync accepted pulse.
  logic        lin_err;  // Sync rejected pulse.
  logic        setup;    // APB setup cycle.
  logic        acc;      // APB access cycle.
  logic        wr;       // Write taken this edge.
  logic        rd;       // Read taken this edge.
  logic        mapped;   // Address hits a register.
  logic [31:0] rdata;    // Read mux.
  logic [3:0]  nbits;    // Data bits per frame.

  //============================================================================
  // Input synchronisation and sync field checker.
  utq_sync2 #(.W(1), .RST_VAL(1'b1)) u_rx_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d_i     (rxd_i),
    .q_o     (rx_s)
  );

  utq_lin_check u_lin (
    .clk     (clk),
    .sys_rst (sys_rst),
    .en      (q.linen && q.receive_enable_bit),
    .line_i  (rx_s),
    .nom_i   (q.baud),
    .ok_o    (lin_ok),
    .err_o   (lin_err)
  );

  //============================================================================
  // Bus decode. The slave answers with no wait states.
  always_comb begin
    setup  = apb_i.psel && !apb_i.penable;
    acc    = apb_i.psel && apb_i.penable;
    wr     = acc && apb_i.pwrite;
    rd     = acc && !apb_i.pwrite;
    mapped = 1'b1;
    rdata  = 32'h00000000;
    nbits  = q.ch9 ? UTQ_BITS9 : UTQ_BITS8;
    if (apb_i.paddr == UTQ_ADDR_RXL) begin
      rdata[7:0] = q.rxdata[7:0];
    end else if (apb_i.paddr == UTQ_ADDR_RXH) begin
      rdata[UTQ_RXH_D8]   = q.rxdata[8];
      rdata[UTQ_RXH_FRAME_ERROR_FLAG] = q.frame_error_flag;
      rdata[UTQ_RXH_RXC]  = q.rxc;
    end else if (apb_i.paddr == UTQ_ADDR_TXL) begin
      rdata[7:0] = q.txdata[7:0];
    end else if (apb_i.paddr == UTQ_ADDR_TXH) begin
      rdata[7:0] = q.txh;
    end else if (apb_i.paddr == UTQ_ADDR_STAT) begin
      rdata[UTQ_ST_TXDE]  = !q.txd_v;
      rdata[UTQ_ST_TXBE]  = !q.txbuf_v;
      rdata[UTQ_ST_TXIDL] = (q.tx_st == UTQ_TX_IDLE);
      rdata[UTQ_ST_LOK]   = q.lok;
      rdata[UTQ_ST_LERR]  = q.lerr;
      rdata[UTQ_ST_RXLVL] = rx_s;
      rdata[UTQ_ST_OVR]   = q.ovr;
    end else if (apb_i.paddr == UTQ_ADDR_CTRL) begin
      rdata[UTQ_CTRL_RECEIVE_ENABLE_BIT] = q.receive_enable_bit;
      rdata[UTQ_CTRL_TRANSMIT_ENABLE_BIT] = q.transmit_enable_bit;
      rdata[UTQ_CTRL_ODME] = q.odme;
      rdata[UTQ_CTRL_LINE] = q.linen;
      rdata[UTQ_CTRL_CH9]  = q.ch9;
    end else if (apb_i.paddr == UTQ_ADDR_BAUD) begin
      rdata[15:0] = q.baud;
    end else if (apb_i.paddr == UTQ_ADDR_PDIR) begin
      rdata[0] = q.pdir;
    end else begin
      mapped = 1'b0;
    end
  end

  //============================================================================
  // Next state for registers, transmitter, receiver and pin.
  always_comb begin
    d = q;
    if (setup) begin
      d.prdata = rdata;
    end

    // Register writes. The override follows the buggy release of the silicon.
    if (wr && mapped) begin
      if (apb_i.paddr == UTQ_ADDR_CTRL) begin
        d.receive_enable_bit  = apb_i.pwdata[UTQ_CTRL_RECEIVE_ENABLE_BIT];
        d.transmit_enable_bit  = apb_i.pwdata[UTQ_CTRL_TRANSMIT_ENABLE_BIT];
        d.odme  = apb_i.pwdata[UTQ_CTRL_ODME];
        d.linen = apb_i.pwdata[UTQ_CTRL_LINE];
        d.ch9   = apb_i.pwdata[UTQ_CTRL_CH9];
      end else if (apb_i.paddr == UTQ_ADDR_BAUD) begin
        d.baud = apb_i.pwdata[15:0];
      end else if (apb_i.paddr == UTQ_ADDR_PDIR) begin
        d.pdir = apb_i.pwdata[0];
      end else if (apb_i.paddr == UTQ_ADDR_TXH) begin
        d.txh = apb_i.pwdata[7:0];
      end else if (apb_i.paddr == UTQ_ADDR_STAT) begin
        // Sticky bits clear on one; a new verdict below still wins.
        d.lok  = q.lok && !apb_i.pwdata[UTQ_ST_LOK];
        d.lerr = q.lerr && !apb_i.pwdata[UTQ_ST_LERR];
      end
      if (apb_i.paddr == UTQ_ADDR_CTRL && apb_i.pwdata[UTQ_CTRL_TRANSMIT_ENABLE_BIT]) begin
        d.ovr = 1'b1;
      end else if (apb_i.paddr == UTQ_ADDR_CTRL && q.transmit_enable_bit) begin
        // Disabling write: only a live receiver lets the override go.
        d.ovr = q.ovr && !apb_i.pwdata[UTQ_CTRL_RECEIVE_ENABLE_BIT];
      end else if (!q.transmit_enable_bit) begin
        d.ovr = 1'b0;
      end
    end

    // Transmit path, stage one to stage two to shifter, one move per stage.
    if (q.tx_st == UTQ_TX_IDLE && q.txbuf_v && q.transmit_enable_bit) begin
      d.txsh    = q.txbuf;
      d.txbuf_v = 1'b0;
      d.tx_st   = UTQ_TX_START;
      d.tx_cnt  = q.baud - 16'h0001;
      d.tx_bit  = 4'h0;
    end
    if (q.txd_v && !q.txbuf_v) begin
      d.txbuf   = q.txdata;
      d.txbuf_v = 1'b1;
      d.txd_v   = 1'b0;
    end
    if (wr && apb_i.paddr == UTQ_ADDR_TXL && !q.txd_v && q.transmit_enable_bit) begin
      // Loading the low byte commits the word; a full register refuses it.
      d.txdata = {q.txh[0], apb_i.pwdata[7:0]};
      d.txd_v  = 1'b1;
    end

    // Transmitter bit timing.
    if (q.tx_st != UTQ_TX_IDLE) begin
      if (q.tx_cnt != 16'h0000) begin
        d.tx_cnt = q.tx_cnt - 16'h0001;
      end else begin
        d.tx_cnt = q.baud - 16'h0001;
        case (q.tx_st)
          UTQ_TX_START: begin
            d.tx_st = UTQ_TX_DATA;
          end
          UTQ_TX_DATA: begin
            d.txsh   = {1'b1, q.txsh[8:1]};
            d.tx_bit = q.tx_bit + 4'h1;
            if (q.tx_bit == nbits - 4'h1) begin
              d.tx_st = UTQ_TX_STOP;
            end
          end
          default: begin
            d.tx_st = UTQ_TX_IDLE;
          end
        endcase
      end
    end
    case (d.tx_st)
      UTQ_TX_START: d.txline = 1'b0;
      UTQ_TX_DATA:  d.txline = d.txsh[0];
      default:      d.txline = 1'b1;
    endcase

    // Receiver. Reading the low byte pops it; a completed frame wins.
    if (rd && apb_i.paddr == UTQ_ADDR_RXL) begin
      d.rxc = 1'b0;
      if (q.frame_error_flag && !rx_s && q.rx_st == UTQ_RX_IDLE) begin
        // Line still low after a bad frame: the read re-arms start detection.
        d.armed = 1'b1;
      end
    end
    case (q.rx_st)
      UTQ_RX_IDLE: begin
        if (rx_s) begin
          d.armed = 1'b1;
        end else if (q.receive_enable_bit && q.armed) begin
          d.rx_st  = UTQ_RX_START;
          d.armed  = 1'b0;
          d.rx_cnt = q.baud >> 1;
          d.rx_bit = 4'h0;
        end
      end
      default: begin
        if (!q.receive_enable_bit) begin
          d.rx_st = UTQ_RX_IDLE;
        end else if (q.rx_cnt != 16'h0000) begin
          d.rx_cnt = q.rx_cnt - 16'h0001;
        end else begin
          d.rx_cnt = q.baud - 16'h0001;
          if (q.rx_st == UTQ_RX_START) begin
            // Mid-bit check rejects glitches shorter than half a bit.
            d.rx_st = rx_s ? UTQ_RX_IDLE : UTQ_RX_DATA;
          end else if (q.rx_st == UTQ_RX_DATA) begin
            d.rxsh   = q.ch9 ? {rx_s, q.rxsh[8:1]} : {1'b0, rx_s, q.rxsh[7:1]};
            d.rx_bit = q.rx_bit + 4'h1;
            if (q.rx_bit == nbits - 4'h1) begin
              d.rx_st = UTQ_RX_STOP;
            end
          end else begin
            d.rxdata = q.rxsh;
            d.frame_error_flag   = !rx_s;
            d.rxc    = 1'b1;
            d.armed  = rx_s;
            d.rx_st  = UTQ_RX_IDLE;
          end
        end
      end
    endcase

    // Sync field verdicts.
    if (lin_ok) begin
      d.lok = 1'b1;
    end
    if (lin_err) begin
      d.lerr = 1'b1;
    end

    // Pin drive. With direction set to output the pin is driven high even in
    // open-drain mode; only an input direction gives a true pull-low.
    d.pin_oe = d.ovr && (d.pdir || (d.odme && !d.txline));
    d.pin_o  = (d.odme && !d.pdir) ? 1'b0 : d.txline;
  end

  //============================================================================
  // State register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{baud: UTQ_BAUD_RST, tx_st: UTQ_TX_IDLE, rx_st: UTQ_RX_IDLE,
             txline: 1'b1, pin_o: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign prdata  = q.prdata;
  assign pready  = acc;
  assign pslverr = acc && !mapped;
  assign txd_o   = q.pin_o;
  assign txd_oe  = q.pin_oe;

  //============================================================================
  // Checks.
  AST_OVR_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
    (wr && apb_i.paddr == UTQ_ADDR_CTRL && q.transmit_enable_bit && q.ovr
     && !apb_i.pwdata[UTQ_CTRL_TRANSMIT_ENABLE_BIT] && !apb_i.pwdata[UTQ_CTRL_RECEIVE_ENABLE_BIT]) |=> q.ovr)
    else $error("override released while receiver disabled");
  AST_OVR_RELEASE: assert property (@(posedge clk) disable iff (sys_rst)
    (wr && mapped && !q.transmit_enable_bit && apb_i.paddr != UTQ_ADDR_CTRL) |=> !q.ovr && !txd_oe)
    else $error("register write did not release the override");
  AST_FALSE_START: assert property (@(posedge clk) disable iff (sys_rst)
    (rd && apb_i.paddr == UTQ_ADDR_RXL && q.frame_error_flag && !rx_s && q.rx_st == UTQ_RX_IDLE
     && q.receive_enable_bit) ##1 (!rx_s && q.receive_enable_bit) |=> q.rx_st == UTQ_RX_START)
    else $error("no start detected after read with line low");
  AST_OD_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
    (q.ovr && q.pdir && q.txline) |-> txd_oe && txd_o)
    else $error("pin not driven high with output direction");
  AST_OD_PULL: assert property (@(posedge clk) disable iff (sys_rst)
    (q.odme && !q.pdir && txd_oe) |-> !txd_o && !q.txline)
    else $error("open-drain pin driven high");
  AST_TO_BUFFER: assert property (@(posedge clk) disable iff (sys_rst)
    (q.txd_v && !q.txbuf_v) |=> q.txbuf_v && $past(q.txdata) == q.txbuf)
    else $error("data register did not move to buffer");
  AST_TO_SHIFTER: assert property (@(posedge clk) disable iff (sys_rst)
    (q.tx_st == UTQ_TX_IDLE && q.txbuf_v && q.transmit_enable_bit) |=> q.tx_st == UTQ_TX_START ##1
    !txd_o[*2])
    else $error("buffer did not start a frame");
  AST_LIN_STICKY: assert property (@(posedge clk) disable iff (sys_rst)
    lin_err |=> q.lerr)
    else $error("sync reject not recorded");
endmodule : utq_usart

// ==== utq_pkg.sv ====
// Constants, register map and state types for the serial transceiver.
//==============================================================================
// Notes on behaviour
// - Clearing transmit with receiver off keeps pin override.
// - Clearing both enables together keeps pin override.
// - Any later register write releases the override, unless it sets transmit enable.
// - Sync field checks each bit within fifteen percent.
// - Low byte read after frame error re-arms start.
// - Direction output drives pin high despite open drain.
// - Transmit path has data register plus buffer stage.
// - Data moves to buffer, then shifter when empty.
//==============================================================================
package utq_pkg;

  //============================================================================
  // Register byte addresses on the APB bus.
  localparam logic [7:0] UTQ_ADDR_RXL  = 8'h00;  // Receive byte low, read pops.
  localparam logic [7:0] UTQ_ADDR_RXH  = 8'h04;  // Receive byte high and flags.
  localparam logic [7:0] UTQ_ADDR_TXL  = 8'h08;  // Transmit byte low, write loads.
  localparam logic [7:0] UTQ_ADDR_TXH  = 8'h0C;  // Transmit byte high, ninth bit.
  localparam logic [7:0] UTQ_ADDR_STAT = 8'h10;  // Status, sticky bits clear on one.
  localparam logic [7:0] UTQ_ADDR_CTRL = 8'h14;  // Control register B.
  localparam logic [7:0] UTQ_ADDR_BAUD = 8'h18;  // Clock cycles per bit.
  localparam logic [7:0] UTQ_ADDR_PDIR = 8'h1C;  // Port direction of the output pin.

  //============================================================================
  // Field positions.
  localparam int UTQ_CTRL_RECEIVE_ENABLE_BIT = 0;  // Receive enable bit.
  localparam int UTQ_CTRL_TRANSMIT_ENABLE_BIT = 1;  // Transmit enable bit.
  localparam int UTQ_CTRL_ODME = 2;  // Open-drain mode.
  localparam int UTQ_CTRL_LINE = 3;  // Sync field check enable.
  localparam int UTQ_CTRL_CH9  = 4;  // Nine data bits.
  localparam int UTQ_RXH_D8    = 0;  // Ninth received bit.
  localparam int UTQ_RXH_FRAME_ERROR_FLAG  = 2;  // Frame error flag.
  localparam int UTQ_RXH_RXC   = 7;  // Receive complete.
  localparam int UTQ_ST_TXDE   = 0;  // Transmit data register empty.
  localparam int UTQ_ST_TXBE   = 1;  // Transmit buffer empty.
  localparam int UTQ_ST_TXIDL  = 2;  // Shift register idle.
  localparam int UTQ_ST_LOK    = 3;  // Sync field accepted, sticky.
  localparam int UTQ_ST_LERR   = 4;  // Sync field rejected, sticky.
  localparam int UTQ_ST_RXLVL  = 5;  // Synchronised input line level.
  localparam int UTQ_ST_OVR    = 6;  // Pin override active.

  //============================================================================
  // Sizes, reset values and counts.
  localparam int          UTQ_BAUD_W    = 16;        // Bit period counter width.
  localparam logic [15:0] UTQ_BAUD_RST  = 16'h0010;  // Reset bit period in cycles.
  localparam logic [3:0]  UTQ_BITS8     = 4'h8;      // Data bits, normal frame.
  localparam logic [3:0]  UTQ_BITS9     = 4'h9;      // Data bits, nine-bit frame.
  localparam int          UTQ_LIN_TOL   = 15;        // Per-bit tolerance in percent.
  localparam int          UTQ_PCT       = 100;       // Percent scale.
  localparam logic [3:0]  UTQ_LIN_EDGES = 4'h9;      // Edges after the start fall.

  //============================================================================
  // Types.
  typedef enum logic [1:0] {UTQ_TX_IDLE, UTQ_TX_START, UTQ_TX_DATA, UTQ_TX_STOP} utq_tx_st_t;
  typedef enum logic [1:0] {UTQ_RX_IDLE, UTQ_RX_START, UTQ_RX_DATA, UTQ_RX_STOP} utq_rx_st_t;

  typedef struct packed {
    logic        psel;     // Slave selected.
    logic        penable;  // Access phase.
    logic        pwrite;   // Write when high.
    logic [7:0]  paddr;    // Byte address.
    logic [31:0] pwdata;   // Write data.
  } utq_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;   // Read data, registered in the setup cycle.
    logic        receive_enable_bit;     // Receive enable bit.
    logic        transmit_enable_bit;     // Transmit enable bit.
    logic        odme;     // Open-drain mode.
    logic        linen;    // Sync field check enable.
    logic        ch9;      // Nine-bit frames.
    logic [15:0] baud;     // Bit period.
    logic        pdir;     // Port direction, high for output.
    logic [7:0]  txh;      // Transmit byte high.
    logic [8:0]  txdata;   // Transmit data register.
    logic        txd_v;    // Transmit data register full.
    logic [8:0]  txbuf;    // Transmit buffer stage.
    logic        txbuf_v;  // Transmit buffer full.
    logic [8:0]  txsh;     // Output shift register.
    utq_tx_st_t  tx_st;    // Transmitter state.
    logic [15:0] tx_cnt;   // Transmit bit timer.
    logic [3:0]  tx_bit;   // Transmit bit index.
    logic        txline;   // Serial level from the shifter.
    logic        ovr;      // Pin override held.
    utq_rx_st_t  rx_st;    // Receiver state.
    logic [15:0] rx_cnt;   // Receive bit timer.
    logic [3:0]  rx_bit;   // Receive bit index.
    logic [8:0]  rxsh;     // Receive shift register.
    logic [8:0]  rxdata;   // Received word.
    logic        frame_error_flag;     // Frame error flag.
    logic        rxc;      // Receive complete.
    logic        armed;    // Start detection armed.
    logic        lok;      // Sync accepted, sticky.
    logic        lerr;     // Sync rejected, sticky.
    logic        pin_o;    // Pin output value.
    logic        pin_oe;   // Pin output enable.
  } utq_state_t;

  typedef struct packed {
    logic        prev;     // Line level last cycle.
    logic        active;   // Sync field being measured.
    logic [15:0] run;      // Cycles since last edge.
    logic [3:0]  edges;    // Edges accepted so far.
    logic        ok;       // Accept pulse.
    logic        err;      // Reject pulse.
  } utq_lin_t;

endpackage : utq_pkg

// ==== utq_sync2.sv ====
// Two flip-flop synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ns
module utq_sync2 #(
  parameter int         W       = 1,  // Number of bits.
  parameter logic [0:0] RST_VAL = 1'b1  // Level taken under reset.
) (
  input  wire logic         clk,      // System clock.
  input  wire logic         sys_rst,  // Asynchronous reset, active high.
  input  wire logic [W-1:0] d_i,      // Asynchronous input.
  output logic      [W-1:0] q_o       // Synchronised output.
);
  typedef struct packed {
    logic [W-1:0] s1;  // First stage, read only by the second.
    logic [W-1:0] s2;  // Second stage.
  } utq_sync_t;

  utq_sync_t q, d;

  //============================================================================
  // Next state: the first stage feeds only the second stage.
  always_comb begin
    d    = q;
    d.s1 = d_i;
    d.s2 = q.s1;
  end

  // State register, reset to the idle line level.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= {(2*W){RST_VAL}};
    end else begin
      q <= d;
    end
  end

  assign q_o = q.s2;
endmodule : utq_sync2

// ==== utq_lin_check.sv ====
// Sync field checker that validates each bit period on its own.
`timescale 1ns/1ns
module utq_lin_check
  import utq_pkg::*;
(
  input  wire logic                  clk,      // System clock.
  input  wire logic                  sys_rst,  // Asynchronous reset, active high.
  input  wire logic                  en,       // Check enabled.
  input  wire logic                  line_i,   // Synchronised input line.
  input  wire logic [UTQ_BAUD_W-1:0] nom_i,    // Nominal bit period in cycles.
  output logic                       ok_o,     // Field accepted, one-cycle pulse.
  output logic                       err_o     // Field rejected, one-cycle pulse.
);
  import utq_pkg::*;

  utq_lin_t    q, d;
  logic [23:0] lo;    // Shortest accepted bit.
  logic [23:0] hi;    // Longest accepted bit.
  logic [23:0] len;   // Length of the run that ends now.

  //============================================================================
  // Each run between edges is one bit of the alternating field, so each is
  // checked alone. The trade-off is that duty cycles beyond the per-bit window
  // are refused although edge-to-edge timing would pass them.
  always_comb begin
    d     = q;
    d.ok  = 1'b0;
    d.err = 1'b0;
    lo    = 24'((32'(nom_i) * 32'(UTQ_PCT - UTQ_LIN_TOL)) / 32'(UTQ_PCT));
    hi    = 24'((32'(nom_i) * 32'(UTQ_PCT + UTQ_LIN_TOL)) / 32'(UTQ_PCT));
    len   = 24'(q.run) + 24'h000001;
    d.prev = line_i;
    if (!en) begin
      d.active = 1'b0;
    end else if (!q.active) begin
      // A falling edge opens the start bit of the field.
      if (q.prev && !line_i) begin
        d.active = 1'b1;
        d.run    = '0;
        d.edges  = '0;
      end
    end else if (q.prev != line_i) begin
      d.run = '0;
      if (len < lo || len > hi) begin
        d.err    = 1'b1;
        d.active = 1'b0;
      end else if (q.edges == UTQ_LIN_EDGES - 4'h1) begin
        d.ok     = 1'b1;
        d.active = 1'b0;
      end else begin
        d.edges = q.edges + 4'h1;
      end
    end else if (len > hi) begin
      // A run already too long fails without waiting for its edge.
      d.err    = 1'b1;
      d.active = 1'b0;
    end else begin
      d.run = q.run + 16'h0001;
    end
  end

  // State register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{prev: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign ok_o  = q.ok;
  assign err_o = q.err;

  AST_LIN_OK_COUNT: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(q.ok) |-> $past(q.edges) == UTQ_LIN_EDGES - 4'h1)
    else $error("sync accepted before all edges seen");
  AST_LIN_EXCL: assert property (@(posedge clk) disable iff (sys_rst)
    (q.ok || q.err) |=> !q.active)
    else $error("sync checker still active after a verdict");
endmodule : utq_lin_check

// ==== utq_node.sv ====
// Remote serial node model facing the transceiver pins.
`timescale 1ns/1ns
module utq_node (
  input  wire logic        clk,   // System clock.
  input  wire logic        line,  // Resolved level of the output pin.
  input  wire logic [15:0] bt,    // Bit time in clocks.
  output logic             rxd    // Line toward the device input.
);
  logic [7:0] got[$];  // Bytes heard on the line.
  logic [7:0] sh;      // Receive shift register.
  initial rxd = 1'b1;
  // Holds a level for n clocks; a frame may end low to mimic a stuck line.
  task automatic seg(input logic v, input int n);
    rxd <= v;
    repeat (n) @(posedge clk);
  endtask : seg
  // Sends start, eight bits LSB first, then a stop bit of the given level.
  task automatic send(input logic [7:0] b, input logic stp);
    seg(1'b0, bt);
    for (int i = 0; i < 8; i++) seg(b[i], bt);
    seg(stp, bt);
  endtask : send
  // Samples mid-bit, as a plain receiver on the far side would.
  always begin
    @(negedge line);
    repeat (bt / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bt) @(posedge clk);
      sh[i] = line;
    end
    repeat (bt) @(posedge clk);
    got.push_back(sh);
  end
endmodule : utq_node

// ==== tb.sv ====
// Self-checking bench for the serial transceiver.
`timescale 1ns/1ns
module tb;
  import utq_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d, q; logic e;} utq_tb_row_t;
  logic clk, sys_rst, pready, pslverr, rxd, txd_o, txd_oe, er;
  logic [31:0] prdata, rd;
  logic [15:0] bt = 16'h0008;
  utq_apb_req_t apb = '0;
  int n_fail = 0, cmp_count = 0, k;
  wire line = txd_oe ? txd_o : 1'b1;  // Pull-up when the pin is not driven.
  utq_tb_row_t rows[6] = '{'{1'h0, UTQ_ADDR_BAUD, 32'h0, 32'h10, 1'h0},
    '{1'h0, UTQ_ADDR_STAT, 32'h0, 32'h27, 1'h0}, '{1'h0, 8'h20, 32'h0, 32'h0, 1'h1},
    '{1'h1, UTQ_ADDR_RXH, 32'hFF, 32'h0, 1'h0}, '{1'h0, UTQ_ADDR_RXH, 32'h0, 32'h0, 1'h0},
    '{1'h1, UTQ_ADDR_BAUD, 32'h8, 32'h0, 1'h0}};
  logic [8:0] ov[3] = '{9'h041, 9'h061, 9'h062};  // First CTRL, second CTRL, override.
  logic [15:0] syn[4] = '{16'h1414, 16'h1711, 16'h1810, 16'h1216};  // Low, high runs.
  utq_usart uut (.clk(clk), .sys_rst(sys_rst), .apb_i(apb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_i(rxd), .txd_o(txd_o), .txd_oe(txd_oe));
  utq_node node (.clk(clk), .line(line), .bt(bt), .rxd(rxd));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    cmp_count++;
    if (g !== x) begin
      n_fail++;
      $display("BAD %0t %s got %h want %h", $time, m, g, x);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen at a rising edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    apb <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge clk);
    apb.penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge clk);
    rd = prdata;
    er = pslverr;
    apb <= '0;
    @(posedge clk);
    if (k == 20) begin
      n_fail++;
      wrap_up();
    end
  endtask : bus
  // Reads a register and compares the masked value.
  task automatic rdc(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(rd & msk, x, "read");
  endtask : rdc
  initial begin
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk({txd_oe, txd_o}, 32'h1, "idle pin");
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      chk(er, rows[i].e, "error flag");
      chk(rows[i].w ? 32'h0 : rd, rows[i].q, "row");
    end
    $display("register rows done");
    bus(1'b1, UTQ_ADDR_PDIR, 32'h1);
    foreach (ov[i]) begin
      bus(1'b1, UTQ_ADDR_CTRL, ov[i][8:5]);
      bus(1'b1, UTQ_ADDR_CTRL, ov[i][4:1]);
      rdc(UTQ_ADDR_STAT, 32'h40, {ov[i][0], 6'h0});
      chk(txd_oe, ov[i][0], "held pin");
      bus(1'b1, UTQ_ADDR_BAUD, 32'h8);
      chk(txd_oe, 32'h0, "release");
    end
    $display("override test done");
    bus(1'b1, UTQ_ADDR_CTRL, 32'h3);
    foreach (ov[i]) bus(1'b1, UTQ_ADDR_TXL, {ov[i], 2'h1});
    rdc(UTQ_ADDR_STAT, 32'h7, 32'h0);
    bus(1'b1, UTQ_ADDR_TXL, 32'h99);  // A full data register drops this word.
    for (k = 0; k < 500 && node.got.size() < 3; k++) @(posedge clk);
    repeat (200) @(posedge clk);
    chk(node.got.size(), 32'h3, "words sent");
    foreach (node.got[i]) chk(node.got[i], {ov[i][5:0], 2'h1}, "tx byte");
    $display("transmit test done");
    bus(1'b1, UTQ_ADDR_CTRL, 32'h6);
    chk({txd_oe, txd_o}, 32'h3, "od drive");
    bus(1'b1, UTQ_ADDR_PDIR, 32'h0);
    chk(txd_oe, 32'h0, "od input");
    bus(1'b1, UTQ_ADDR_CTRL, 32'h9);
    bus(1'b1, UTQ_ADDR_BAUD, 32'h14);
    bt = 16'h0014;
    foreach (syn[i]) begin
      for (int j = 0; j < 9; j++) node.seg(j[0], j[0] ? syn[i][7:0] : syn[i][15:8]);
      node.seg(1'b1, 60);
      rdc(UTQ_ADDR_STAT, 32'h18, (i == 2) ? 32'h10 : 32'h08);
      bus(1'b1, UTQ_ADDR_STAT, 32'h18);
    end
    $display("sync test done");
    bus(1'b1, UTQ_ADDR_CTRL, 32'h1);
    bus(1'b1, UTQ_ADDR_BAUD, 32'h8);
    bt = 16'h0008;
    bus(1'b0, UTQ_ADDR_RXL, 32'h0);
    node.send(8'h3C, 1'b0);
    rdc(UTQ_ADDR_RXH, 32'h85, 32'h84);
    rdc(UTQ_ADDR_RXL, 32'hFF, 32'h3C);
    node.seg(1'b0, 96);
    rdc(UTQ_ADDR_RXH, 32'h80, 32'h80);
    node.seg(1'b1, 16);
    bus(1'b0, UTQ_ADDR_RXL, 32'h0);
    repeat (96) @(posedge clk);
    rdc(UTQ_ADDR_RXH, 32'h80, 32'h0);
    $display("frame error test done");
    wrap_up();
  end
endmodule : tb
